/* File: design/pbvc_pkg.sv */
// Package for the push-button voice control front end.
// Assumes a single 40 MHz clock and synchronous button inputs.
// Overview of operation
// R1 - Standalone: held low passthrough request enables auxiliary feed-through path.
// R2 - Feed-through routes auxiliary input to speaker and auxiliary output with volume.
// R3 - SPI mode ignores passthrough pin; enable comes from route config bit six.
// R4 - One low pulse on play while idle starts playback.
// R5 - Playback ends by itself at the end of the message.
// R6 - Another play pulse during playback stops it.
// R7 - Play held low loops messages; looping stops when released.
// R8 - Recording begins on capture falling edge that then stays low.
// R9 - Recording stops as soon as capture input returns high.
// R10 - Erase happens only at first or last message; otherwise ignored.
// R11 - Short erase pulse deletes the current message.
// R12 - Erase held over three seconds erases every message.
// R13 - While powered down, skip moves pointer to the next message.
// R14 - Skip during playback stops, advances, then restarts playback.
// R15 - Status output is open drain: driven low or released.
// R16 - Standalone: status low during operations, released when powered down.
// R17 - SPI mode: status goes low as interrupt when a command completes.
// R18 - Interrupt holds until host clears it, then status returns high.
// R19 - Capture input debounced on its starting edge only.
// R20 - Passthrough, play, erase, skip debounced on both edges.
// R21 - Debounce and global-erase hold are clock counts from parameters.
// R22 - Standalone message placement handled internally; no user addresses.
`default_nettype none

package pbvc_pkg;

    localparam int unsigned CLK_HZ = 40_000_000;
    // Debounce interval in microseconds and global erase hold in milliseconds
    localparam int unsigned DEBOUNCE_INTERVAL_US = 20_000;
    localparam int unsigned GLOBAL_ERASE_MS = 3_000;
    localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_INTERVAL_US;
    localparam int unsigned GLOBAL_ERASE_CYC = (CLK_HZ / 1_000) * GLOBAL_ERASE_MS;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned FEED_THROUGH_BIT = 6;
    localparam int unsigned ROUTE_CFG_W = 12;
    localparam int unsigned PTR_W = 8;
    localparam logic [PTR_W-1:0] PTR_RESET = 8'h00;

    typedef enum logic [2:0] {
        PBVC_IDLE = 3'b000,
        PBVC_PLAY = 3'b001,
        PBVC_REC = 3'b011,
        PBVC_ERASE = 3'b010,
        PBVC_SKIP = 3'b110,
        PBVC_GERASE = 3'b111
    } pbvc_state_e;

    typedef struct packed {
        logic passthrough;
        logic play;
        logic capture;
        logic erase;
        logic skip;
    } pbvc_buttons_s;

    typedef struct packed {
        logic play;
        logic record;
        logic erase_one;
        logic erase_all;
        logic advance;
    } pbvc_ops_s;

endpackage : pbvc_pkg

`default_nettype wire

/* File: design/pbvc_debounce.sv */
// Button debouncer for one active-low input.
// Assumes input synchronous to clk_i; both_edges selects end-edge filtering.
`default_nettype none

module pbvc_debounce #(
    parameter int unsigned CYCLES = pbvc_pkg::DEBOUNCE_CYC,
    parameter bit BOTH_EDGES = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic button_n_i,
    output logic pressed_o
);

    logic [pbvc_pkg::CNT_W-1:0] count;
    logic pressed;
    logic differs;

    assign differs = (~button_n_i) != pressed;
    assign pressed_o = pressed;

    // R19 R20 - stable-interval filter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= '0;
            pressed <= 1'b0;
        end else if (!differs) begin
            count <= '0;
        end else if (pressed && !BOTH_EDGES) begin
            // Release taken at once when only the start edge is filtered
            pressed <= 1'b0;
            count <= '0;
        end else if (count >= CYCLES[pbvc_pkg::CNT_W-1:0] - 1'b1) begin
            pressed <= ~pressed;
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

endmodule : pbvc_debounce

`default_nettype wire

/* File: design/pbvc_status_pin.sv */
// Open-drain ready/interrupt pin driver with sticky interrupt.
// Assumes the host clears the interrupt with a one-cycle pulse.
`default_nettype none

module pbvc_status_pin (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic spi_mode_i,
    input wire logic busy_i,
    input wire logic cmd_done_i,
    input wire logic int_clear_i,
    output logic status_o,
    output logic status_oe_o,
    output logic int_pending_o
);

    logic int_pending;
    logic drive_low;

    // R17 R18 - sticky interrupt, set wins over clear
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_pending <= 1'b0;
        end else if (cmd_done_i && spi_mode_i) begin
            int_pending <= 1'b1;
        end else if (int_clear_i) begin
            int_pending <= 1'b0;
        end
    end

    // R16 - ready low while busy in standalone mode
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            drive_low <= 1'b0;
        end else begin
            drive_low <= spi_mode_i ? (int_pending || (cmd_done_i && !int_clear_i) ||
                                       cmd_done_i) : busy_i;
        end
    end

    // R15 - only ever driven low
    assign status_o = 1'b0;
    assign status_oe_o = drive_low;
    assign int_pending_o = int_pending;

endmodule : pbvc_status_pin

`default_nettype wire

/* File: design/pbvc_top.sv */
// Push-button control front end: debounce, operation sequencing, status pin.
// Assumes synchronous buttons, message end, erase done and command done from the storage core.
`default_nettype none

module pbvc_top #(
    parameter int unsigned DEBOUNCE_CYCLES = pbvc_pkg::DEBOUNCE_CYC,
    parameter int unsigned GLOBAL_ERASE_CYCLES = pbvc_pkg::GLOBAL_ERASE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic spi_mode_i,
    input wire pbvc_pkg::pbvc_buttons_s buttons_n_i,
    input wire logic [pbvc_pkg::ROUTE_CFG_W-1:0] analog_route_config_i,
    input wire logic message_end_i,
    input wire logic erase_done_i,
    input wire logic cmd_done_i,
    input wire logic int_clear_i,
    input wire logic [pbvc_pkg::PTR_W-1:0] last_message_i,
    output logic feed_through_o,
    output logic auxiliary_output_o,
    output pbvc_pkg::pbvc_ops_s ops_o,
    output logic [pbvc_pkg::PTR_W-1:0] message_ptr_o,
    output logic status_o,
    output logic status_oe_o,
    output logic int_pending_o
);

    // ------------------------------------------------------------------
    // Debounce
    // ------------------------------------------------------------------
    pbvc_pkg::pbvc_buttons_s pressed;
    pbvc_pkg::pbvc_buttons_s pressed_d;
    pbvc_pkg::pbvc_buttons_s fall;
    pbvc_pkg::pbvc_buttons_s rise;

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_deb
            // R19 R20 R21 - capture filtered on start only
            pbvc_debounce #(
                .CYCLES(DEBOUNCE_CYCLES),
                .BOTH_EDGES(gi != 2)
            ) u_deb (
                .clk_i(clk_i),
                .rst_n_i(rst_n_i),
                .button_n_i(buttons_n_i[gi]),
                .pressed_o(pressed[gi])
            );
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pressed_d <= '0;
        end else begin
            pressed_d <= pressed;
        end
    end

    assign fall = pressed & ~pressed_d;
    assign rise = ~pressed & pressed_d;

    // ------------------------------------------------------------------
    // Feed-through
    // ------------------------------------------------------------------
    // R1 R2 R3 - pin in standalone, config bit in SPI
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            feed_through_o <= 1'b0;
        end else if (spi_mode_i) begin
            feed_through_o <= analog_route_config_i[pbvc_pkg::FEED_THROUGH_BIT];
        end else begin
            feed_through_o <= pressed.passthrough;
        end
    end

    // R2 - auxiliary output carries feed-through or playback
    assign auxiliary_output_o = feed_through_o | ops_o.play;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    pbvc_pkg::pbvc_state_e state;
    pbvc_pkg::pbvc_state_e next_state;
    logic [pbvc_pkg::CNT_W-1:0] hold_count;
    logic [pbvc_pkg::PTR_W-1:0] ptr;
    logic [pbvc_pkg::PTR_W-1:0] next_ptr;
    logic at_edge_msg;
    logic play_held;
    logic standalone;
    logic skip_from_play;
    logic erase_seen;

    assign standalone = !spi_mode_i;
    // R10 - erase permitted only at first or last message
    assign at_edge_msg = (ptr == pbvc_pkg::PTR_RESET) || (ptr == last_message_i);

    // ------------------------------------------------------------------
    // Erase hold and loop request
    // ------------------------------------------------------------------
    // R21 - hold threshold counted in clocks
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hold_count <= '0;
        end else if (!pressed.erase) begin
            hold_count <= '0;
        end else if (hold_count != GLOBAL_ERASE_CYCLES[pbvc_pkg::CNT_W-1:0]) begin
            hold_count <= hold_count + 1'b1;
        end
    end

    // Play held past debounce counts as a loop request
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            play_held <= 1'b0;
        end else begin
            play_held <= pressed.play && (state == pbvc_pkg::PBVC_PLAY);
        end
    end

    // Storage core may finish before the button is released
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            erase_seen <= 1'b0;
        end else if (state != pbvc_pkg::PBVC_GERASE) begin
            erase_seen <= 1'b0;
        end else if (erase_done_i) begin
            erase_seen <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_ptr = ptr;
        case (state)
            pbvc_pkg::PBVC_IDLE: begin
                if (standalone) begin
                    if (fall.capture) begin
                        // R8 - start recording on falling edge
                        next_state = pbvc_pkg::PBVC_REC;
                    end else if (fall.play) begin
                        // R4 - pulse from idle starts playback
                        next_state = pbvc_pkg::PBVC_PLAY;
                    end else if (rise.erase && at_edge_msg) begin
                        // R11 - short pulse deletes current message
                        next_state = pbvc_pkg::PBVC_ERASE;
                    end else if (pressed.erase && at_edge_msg &&
                                 hold_count == GLOBAL_ERASE_CYCLES[pbvc_pkg::CNT_W-1:0]) begin
                        // R12 - long hold erases everything
                        next_state = pbvc_pkg::PBVC_GERASE;
                    end else if (fall.skip) begin
                        // R13 - advance pointer while powered down
                        next_state = pbvc_pkg::PBVC_SKIP;
                    end
                end
            end
            pbvc_pkg::PBVC_PLAY: begin
                if (fall.skip) begin
                    // R14 - stop, advance, restart
                    next_state = pbvc_pkg::PBVC_SKIP;
                end else if (fall.play) begin
                    // R6 - second pulse stops playback
                    next_state = pbvc_pkg::PBVC_IDLE;
                end else if (message_end_i) begin
                    // R7 R22 - loop on held play, else stop at end
                    if (play_held) begin
                        next_ptr = (ptr == last_message_i) ? pbvc_pkg::PTR_RESET
                                                           : ptr + 1'b1;
                    end else begin
                        // R5 - automatic stop at message end
                        next_state = pbvc_pkg::PBVC_IDLE;
                    end
                end
            end
            pbvc_pkg::PBVC_REC: begin
                // R9 - stop once capture released
                if (!pressed.capture) begin
                    next_state = pbvc_pkg::PBVC_IDLE;
                    next_ptr = last_message_i + 1'b1;
                end
            end
            pbvc_pkg::PBVC_ERASE: begin
                if (erase_done_i) begin
                    next_state = pbvc_pkg::PBVC_IDLE;
                    next_ptr = (ptr == pbvc_pkg::PTR_RESET) ? ptr : ptr - 1'b1;
                end
            end
            pbvc_pkg::PBVC_GERASE: begin
                if ((erase_done_i || erase_seen) && !pressed.erase) begin
                    next_state = pbvc_pkg::PBVC_IDLE;
                    next_ptr = pbvc_pkg::PTR_RESET;
                end
            end
            pbvc_pkg::PBVC_SKIP: begin
                // R22 - pointer wraps internally
                next_ptr = (ptr == last_message_i) ? pbvc_pkg::PTR_RESET : ptr + 1'b1;
                // R14 - restart only if skip came from playback
                next_state = skip_from_play ? pbvc_pkg::PBVC_PLAY : pbvc_pkg::PBVC_IDLE;
            end
            default: begin
                next_state = pbvc_pkg::PBVC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State and pointer registers
    // ------------------------------------------------------------------
    // R14 - remembers whether a skip resumes playback
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            skip_from_play <= 1'b0;
        end else if (state == pbvc_pkg::PBVC_PLAY) begin
            skip_from_play <= 1'b1;
        end else if (state == pbvc_pkg::PBVC_IDLE) begin
            skip_from_play <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= pbvc_pkg::PBVC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr <= pbvc_pkg::PTR_RESET;
        end else begin
            ptr <= next_ptr;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ops_o <= '0;
        end else begin
            ops_o.play <= (next_state == pbvc_pkg::PBVC_PLAY);
            ops_o.record <= (next_state == pbvc_pkg::PBVC_REC);
            ops_o.erase_one <= (next_state == pbvc_pkg::PBVC_ERASE);
            ops_o.erase_all <= (next_state == pbvc_pkg::PBVC_GERASE);
            ops_o.advance <= (next_state == pbvc_pkg::PBVC_SKIP);
        end
    end

    assign message_ptr_o = ptr;

    // ------------------------------------------------------------------
    // Ready and interrupt pin
    // ------------------------------------------------------------------
    // R15 R16 R17 R18 - ready and interrupt pin
    pbvc_status_pin u_status (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .spi_mode_i(spi_mode_i),
        .busy_i(state != pbvc_pkg::PBVC_IDLE),
        .cmd_done_i(cmd_done_i),
        .int_clear_i(int_clear_i),
        .status_o(status_o),
        .status_oe_o(status_oe_o),
        .int_pending_o(int_pending_o)
    );

endmodule : pbvc_top

`default_nettype wire

/* File: sim/pbvc_properties.sv */
// Concurrent checks on the ports of the push-button control front end.
// Assumes one clock and an asynchronous active-low reset.
`default_nettype none

module pbvc_properties #(
    parameter int unsigned DEBOUNCE_CYCLES = 4,
    parameter int unsigned GLOBAL_ERASE_CYCLES = 50
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic spi_mode_i,
    input wire pbvc_pkg::pbvc_buttons_s buttons_n_i,
    input wire logic [pbvc_pkg::ROUTE_CFG_W-1:0] analog_route_config_i,
    input wire logic message_end_i,
    input wire logic erase_done_i,
    input wire logic cmd_done_i,
    input wire logic int_clear_i,
    input wire logic [pbvc_pkg::PTR_W-1:0] last_message_i,
    input wire logic feed_through_o,
    input wire logic auxiliary_output_o,
    input wire pbvc_pkg::pbvc_ops_s ops_o,
    input wire logic [pbvc_pkg::PTR_W-1:0] message_ptr_o,
    input wire logic status_o,
    input wire logic status_oe_o,
    input wire logic int_pending_o
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Consecutive low samples on the erase button
    logic [pbvc_pkg::CNT_W-1:0] erase_low_count;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            erase_low_count <= '0;
        end else if (buttons_n_i.erase) begin
            erase_low_count <= '0;
        end else if (erase_low_count < GLOBAL_ERASE_CYCLES) begin
            erase_low_count <= erase_low_count + 1'b1;
        end
    end

    open_drain_low_a: assert property (status_o == 1'b0)
        else $error("status data not low");
    irq_set_a: assert property (spi_mode_i && cmd_done_i |=> int_pending_o)
        else $error("interrupt not raised");
    irq_hold_a: assert property (int_pending_o && !int_clear_i |=> int_pending_o)
        else $error("interrupt dropped early");
    irq_clear_a: assert property (
        int_pending_o && int_clear_i && !cmd_done_i |=> !int_pending_o)
        else $error("interrupt not cleared");
    irq_pin_a: assert property (spi_mode_i && int_pending_o |=> status_oe_o)
        else $error("interrupt not on pin");
    busy_pin_a: assert property (
        !spi_mode_i && (ops_o.play || ops_o.record) |=> status_oe_o)
        else $error("busy not on pin");
    idle_release_a: assert property (
        !spi_mode_i && !int_pending_o && ops_o == '0 [*4] |=> !status_oe_o)
        else $error("pin held while idle");
    rec_stop_a: assert property (
        ops_o.record && buttons_n_i.capture |-> ##[1:3] !ops_o.record)
        else $error("recording not stopped");
    spi_quiet_a: assert property (spi_mode_i && ops_o == '0 |=> ops_o == '0)
        else $error("button acted in spi mode");
    feed_cfg_a: assert property (
        $past(spi_mode_i) && spi_mode_i |->
        feed_through_o == $past(analog_route_config_i[pbvc_pkg::FEED_THROUGH_BIT]))
        else $error("feed-through not from config");
    skip_one_cycle_a: assert property (ops_o.advance |=> !ops_o.advance)
        else $error("advance held too long");
    erase_place_a: assert property (
        $rose(ops_o.erase_one) |-> message_ptr_o == 8'h00 || message_ptr_o == last_message_i)
        else $error("erase away from end message");
    gerase_hold_a: assert property (
        $rose(ops_o.erase_all) |-> erase_low_count >= GLOBAL_ERASE_CYCLES)
        else $error("global erase too early");
endmodule : pbvc_properties

bind pbvc_top pbvc_properties #(
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES),
    .GLOBAL_ERASE_CYCLES(GLOBAL_ERASE_CYCLES)
) u_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .spi_mode_i(spi_mode_i), .buttons_n_i(buttons_n_i),
    .analog_route_config_i(analog_route_config_i), .message_end_i(message_end_i),
    .erase_done_i(erase_done_i), .cmd_done_i(cmd_done_i), .int_clear_i(int_clear_i),
    .last_message_i(last_message_i), .feed_through_o(feed_through_o),
    .auxiliary_output_o(auxiliary_output_o), .ops_o(ops_o), .message_ptr_o(message_ptr_o),
    .status_o(status_o), .status_oe_o(status_oe_o), .int_pending_o(int_pending_o)
);

`default_nettype wire

/* File: sim/pbvc_button_model.sv */
// Push-button model with contact bounce on every change of a button.
// Assumes the bench changes the wanted levels just after a clock edge.
`default_nettype none

module pbvc_button_model (
    input wire logic clk_i,
    input wire pbvc_pkg::pbvc_buttons_s want_n_i,
    output pbvc_pkg::pbvc_buttons_s buttons_n_o
);
    timeunit 1ns;
    timeprecision 100ps;

    pbvc_pkg::pbvc_buttons_s level = 5'h1f;
    pbvc_pkg::pbvc_buttons_s moved = 5'h00;
    logic [1:0] chatter = 2'h0;

    always @(posedge clk_i) begin
        if (want_n_i != level) begin
            moved <= want_n_i ^ level;
            level <= want_n_i;
            chatter <= 2'h2;
        end else if (chatter != 2'h0) begin
            chatter <= chatter - 2'h1;
        end
    end

    assign buttons_n_o = level ^ (chatter[0] ? moved : 5'h00);
endmodule : pbvc_button_model

`default_nettype wire

/* File: sim/pbvc_top_tb.sv */
// Self-checking bench for the push-button control front end.
// Assumes short debounce and erase-hold counts and a pulled-up status line.
`default_nettype none

module pbvc_top_tb;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int unsigned DEB = 4;
    localparam int unsigned GER = 50;
    localparam logic [7:0] LAST = 8'h03;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic spi = 1'b0;
    logic [11:0] cfg = 12'h000;
    logic [3:0] pulses = 4'h0;
    pbvc_pkg::pbvc_buttons_s want_n = 5'h1f;
    pbvc_pkg::pbvc_buttons_s btn_n;
    pbvc_pkg::pbvc_ops_s ops;
    logic feed;
    logic aux;
    logic st;
    logic st_oe;
    logic irq;
    logic [7:0] ptr;
    wire logic line = st_oe ? st : 1'b1;
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    initial begin
        forever #12.5 clk = ~clk;
    end

    pbvc_button_model u_buttons (.clk_i(clk), .want_n_i(want_n), .buttons_n_o(btn_n));

    pbvc_top #(.DEBOUNCE_CYCLES(DEB), .GLOBAL_ERASE_CYCLES(GER)) u_dut (
        .clk_i(clk), .rst_n_i(rst_n), .spi_mode_i(spi), .buttons_n_i(btn_n),
        .analog_route_config_i(cfg), .message_end_i(pulses[3]), .erase_done_i(pulses[2]),
        .cmd_done_i(pulses[1]), .int_clear_i(pulses[0]), .last_message_i(LAST),
        .feed_through_o(feed), .auxiliary_output_o(aux), .ops_o(ops), .message_ptr_o(ptr),
        .status_o(st), .status_oe_o(st_oe), .int_pending_o(irq)
    );

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic wrap_up;
        if (failures == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic hold(input int b, input logic v);
        @(posedge clk);
        want_n[b] <= v;
    endtask : hold

    task automatic hit(input int b, input int n);
        hold(b, 1'b0);
        repeat (n) @(posedge clk);
        want_n[b] <= 1'b1;
        cyc(10);
    endtask : hit

    task automatic pulse(input int k);
        @(posedge clk);
        pulses[k] <= 1'b1;
        @(posedge clk);
        pulses[k] <= 1'b0;
    endtask : pulse

    task automatic wait_op(input int b, input logic v);
        int n;
        n = 0;
        while (ops[b] !== v && n < 100) begin
            @(negedge clk);
            n++;
        end
        chk(ops[b], v);
    endtask : wait_op

    task automatic do_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        spi <= 1'b0;
        cfg <= 12'h000;
        want_n <= 5'h1f;
        pulses <= 4'h0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        cyc(2);
    endtask : do_reset

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_feed;
        do_reset;
        chk(ops, 8'h00);
        chk(ptr, 8'h00);
        chk(line, 8'h01);
        hit(4, 1);
        chk(feed, 8'h00);
        hold(4, 1'b0);
        cyc(10);
        chk(feed, 8'h01);
        chk(aux, 8'h01);
        hold(4, 1'b1);
        cyc(10);
        chk(feed, 8'h00);
        chk(aux, 8'h00);
    endtask : t_feed

    task automatic t_play;
        do_reset;
        hit(3, 8);
        wait_op(4, 1'b1);
        chk(line, 8'h00);
        pulse(3);
        wait_op(4, 1'b0);
        cyc(3);
        chk(line, 8'h01);
        hit(3, 8);
        wait_op(4, 1'b1);
        hit(3, 8);
        wait_op(4, 1'b0);
    endtask : t_play

    task automatic t_loop;
        do_reset;
        hold(3, 1'b0);
        wait_op(4, 1'b1);
        pulse(3);
        cyc(3);
        chk(ptr, 8'h01);
        chk(ops[4], 8'h01);
        hold(3, 1'b1);
        cyc(10);
        pulse(3);
        wait_op(4, 1'b0);
    endtask : t_loop

    task automatic t_rec;
        do_reset;
        hold(2, 1'b0);
        wait_op(3, 1'b1);
        cyc(5);
        hold(2, 1'b1);
        cyc(5);
        chk(ops[3], 8'h00);
        chk(ptr, LAST + 8'h01);
    endtask : t_rec

    task automatic t_erase;
        do_reset;
        hit(0, 8);
        chk(ptr, 8'h01);
        hit(1, 8);
        chk(ops[2], 8'h00);
        do_reset;
        hit(1, 8);
        wait_op(2, 1'b1);
        chk(line, 8'h00);
        pulse(2);
        wait_op(2, 1'b0);
    endtask : t_erase

    task automatic t_gerase;
        do_reset;
        hold(1, 1'b0);
        cyc(30);
        chk(ops[1], 8'h00);
        wait_op(1, 1'b1);
        hold(1, 1'b1);
        pulse(2);
        wait_op(1, 1'b0);
    endtask : t_gerase

    task automatic t_skip;
        do_reset;
        hit(3, 8);
        wait_op(4, 1'b1);
        hold(0, 1'b0);
        wait_op(0, 1'b1);
        hold(0, 1'b1);
        wait_op(4, 1'b1);
        chk(ptr, 8'h01);
    endtask : t_skip

    task automatic t_spi;
        do_reset;
        @(posedge clk);
        spi <= 1'b1;
        cfg <= 12'h040;
        cyc(4);
        chk(feed, 8'h01);
        hold(4, 1'b0);
        @(posedge clk);
        cfg <= 12'h000;
        cyc(10);
        chk(feed, 8'h00);
        hit(3, 8);
        chk(ops, 8'h00);
        pulse(1);
        cyc(3);
        chk(irq, 8'h01);
        chk(line, 8'h00);
        cyc(20);
        chk(line, 8'h00);
        pulse(0);
        cyc(3);
        chk(line, 8'h01);
        chk(irq, 8'h00);
    endtask : t_spi

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            wrap_up;
        end
    end

    initial begin
        do_reset;
        t_feed;
        t_play;
        t_loop;
        t_rec;
        t_erase;
        t_gerase;
        t_skip;
        t_spi;
        wrap_up;
    end
endmodule : pbvc_top_tb

`default_nettype wire
